// File: bench/eepwc_tb.sv
`timescale 1ns/1ns
`include "eepwc_defs.svh"
module tb;
	// clock, reset and core bus
	logic       i_mclk      = 1'b0;
	logic       i_sys_rst   = 1'b1;
	logic       i_sfr_wr    = 1'b0;
	logic [7:0] i_sfr_addr  = 8'h00;
	logic [7:0] i_sfr_wdata = 8'h00;
	logic       i_instr_end = 1'b0;
	// interrupt side and power mode
	logic       i_glob      = 1'b1;
	logic       i_nven      = 1'b1;
	logic       i_mfen      = 1'b1;
	logic       i_stack     = 1'b1;
	logic       i_ack       = 1'b0;
	logic       i_clr       = 1'b0;
	logic       i_sleep     = 1'b0;
	// design outputs
	logic [7:0] o_sfr_rdata;
	logic       o_nv, o_mf, o_irq, o_busy;
	int         errors      = 0;
	int         compares    = 0;
	int         cycles      = 0;
	// short timer keeps each array cycle at eight clocks
	eepwc_ctrl #(.CYC_CYCLES(8)) dut (
		.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_sfr_wr(i_sfr_wr),
		.i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
		.i_instr_end(i_instr_end), .o_sfr_rdata(o_sfr_rdata),
		.i_global_irq_enable(i_glob), .i_nv_irq_enable(i_nven),
		.i_mf_irq_enable(i_mfen), .i_stack_full(i_stack), .i_irq_ack(i_ack),
		.i_nv_flag_clr(i_clr), .o_nv_irq_flag(o_nv), .o_mf_irq_flag(o_mf),
		.o_irq_req(o_irq), .i_sleep(i_sleep), .o_busy(o_busy));
	// 10 mhz clock
	always #50 i_mclk = ~i_mclk;
	// hang guard, well above the few hundred cycles used
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			results();
		end
	end
	task automatic results();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one instruction writing a register; a strobe ends an instruction too
	// a quiet cycle follows, so no strobe is lowered and raised at once
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_sfr_addr  = a;
		i_sfr_wdata = d;
		i_sfr_wr    = 1'b1;
		i_instr_end = 1'b1;
		@(posedge i_mclk);
		#10;
		i_sfr_wr    = 1'b0;
		i_instr_end = 1'b0;
		@(posedge i_mclk);
		#10;
	endtask
	// one cycle pulse of both flag clears
	task automatic clr_flags();
		i_ack = 1'b1;
		i_clr = 1'b1;
		@(posedge i_mclk);
		#10;
		i_ack = 1'b0;
		i_clr = 1'b0;
	endtask
	// read data is registered one edge after the address
	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		i_sfr_addr = a;
		@(posedge i_mclk);
		#10;
		chk(what, exp, o_sfr_rdata);
	endtask
	task automatic tag16(input logic [7:0] base);
		for (int i = 0; i < 17; i++)
			wr(`EEPWC_A_DATA, base + 8'(i));
	endtask
	// interrupts masked around the enable/start pair
	task automatic unlock(input logic [7:0] en, input logic [7:0] st, input logic gap);
		i_glob = 1'b0;
		wr(`EEPWC_A_IND1, en);
		if (gap) begin
			i_instr_end = 1'b1;
			@(posedge i_mclk);
			#10;
			i_instr_end = 1'b0;
			@(posedge i_mclk);
			#10;
		end
		wr(`EEPWC_A_IND1, st);
		i_glob = 1'b1;
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 40 && o_busy !== 1'b0; i++) begin
			@(posedge i_mclk);
			#10;
		end
		repeat (3) @(posedge i_mclk);
		#10;
	endtask
	// reads the byte at address low lo through the data port, md picks page mode
	task automatic rd_byte(input logic [7:0] lo, input logic md, input logic [7:0] exp);
		wr(`EEPWC_A_ADDR_LO, lo);
		wr(`EEPWC_A_IND1, {3'h0, md, 4'h2});
		wr(`EEPWC_A_IND1, {3'h0, md, 4'h3});
		repeat (2) @(posedge i_mclk);
		#10;
		rchk("array byte", `EEPWC_A_DATA, exp);
		wr(`EEPWC_A_IND1, {3'h0, md, 4'h0});
	endtask
	task automatic t_protect();
		rchk("pointer high", `EEPWC_A_PTR1_HI, 8'h00);
		wr(`EEPWC_A_PTR1_LO, 8'h40);
		wr(`EEPWC_A_IND1, 8'h18);
		wr(`EEPWC_A_PTR1_HI, 8'h01);
		rchk("control", `EEPWC_A_IND1, 8'h00);
		$display("test protect done");
	endtask
	task automatic t_erase();
		wr(`EEPWC_A_IND1, 8'h10);
		rchk("mode", `EEPWC_A_IND1, 8'h10);
		wr(`EEPWC_A_ADDR_HI, 8'h00);
		wr(`EEPWC_A_ADDR_LO, 8'h20);
		tag16(8'h00);
		unlock(8'h50, 8'h70, 1'b1);
		rchk("late start", `EEPWC_A_IND1, 8'h50);
		wr(`EEPWC_A_IND1, 8'h10);
		wr(`EEPWC_A_ADDR_LO, 8'h20);
		tag16(8'h00);
		unlock(8'h50, 8'h70, 1'b0);
		rchk("erase busy", `EEPWC_A_IND1, 8'h70);
		chk("busy", 8'h01, {7'h00, o_busy});
		wait_idle();
		chk("idle", 8'h00, {7'h00, o_busy});
		rchk("erase end", `EEPWC_A_IND1, 8'h10);
		chk("nv flag", 8'h01, {7'h00, o_nv});
		chk("mf flag", 8'h01, {7'h00, o_mf});
		chk("irq stack full", 8'h00, {7'h00, o_irq});
		i_stack = 1'b0;
		i_mfen  = 1'b0;
		repeat (2) @(posedge i_mclk);
		#10;
		chk("irq mf masked", 8'h00, {7'h00, o_irq});
		i_mfen  = 1'b1;
		i_nven  = 1'b0;
		repeat (2) @(posedge i_mclk);
		#10;
		chk("irq nv masked", 8'h00, {7'h00, o_irq});
		i_nven  = 1'b1;
		repeat (2) @(posedge i_mclk);
		#10;
		chk("irq", 8'h01, {7'h00, o_irq});
		i_ack = 1'b1;
		@(posedge i_mclk);
		#10;
		i_ack = 1'b0;
		@(posedge i_mclk);
		#10;
		chk("mf after ack", 8'h00, {7'h00, o_mf});
		chk("nv after ack", 8'h01, {7'h00, o_nv});
		i_clr = 1'b1;
		@(posedge i_mclk);
		#10;
		i_clr = 1'b0;
		chk("nv after clear", 8'h00, {7'h00, o_nv});
		rd_byte(8'h25, 1'b1, 8'h00);
		$display("test erase done");
	endtask
	task automatic t_write();
		wr(`EEPWC_A_ADDR_LO, 8'h20);
		tag16(8'ha0);
		rchk("address low", `EEPWC_A_ADDR_LO, 8'h2f);
		wr(`EEPWC_A_IND1, 8'h14);
		rchk("start alone", `EEPWC_A_IND1, 8'h10);
		unlock(8'h18, 8'h1c, 1'b0);
		wr(`EEPWC_A_DATA, 8'h55);
		rchk("write busy", `EEPWC_A_IND1, 8'h1c);
		wait_idle();
		rchk("write end", `EEPWC_A_IND1, 8'h10);
		chk("nv flag", 8'h01, {7'h00, o_nv});
		rd_byte(8'h20, 1'b1, 8'ha0);
		rd_byte(8'h2f, 1'b1, 8'haf);
		$display("test write done");
	endtask
	// byte mode write with a data write while busy, then a cycle cut by sleep
	task automatic t_byte();
		clr_flags();
		wr(`EEPWC_A_IND1, 8'h00);
		wr(`EEPWC_A_ADDR_LO, 8'h31);
		wr(`EEPWC_A_DATA, 8'h5a);
		unlock(8'h08, 8'h0c, 1'b0);
		wr(`EEPWC_A_DATA, 8'h66);
		rchk("byte busy", `EEPWC_A_IND1, 8'h0c);
		wait_idle();
		rchk("byte end", `EEPWC_A_IND1, 8'h00);
		chk("byte flag", 8'h01, {7'h00, o_nv});
		rd_byte(8'h31, 1'b0, 8'h5a);
		clr_flags();
		wr(`EEPWC_A_DATA, 8'h77);
		unlock(8'h08, 8'h0c, 1'b0);
		i_sleep = 1'b1;
		@(posedge i_mclk);
		#10;
		i_sleep = 1'b0;
		rchk("after sleep", `EEPWC_A_IND1, 8'h00);
		chk("busy after sleep", 8'h00, {7'h00, o_busy});
		chk("no flag on abort", 8'h00, {7'h00, o_nv});
		rd_byte(8'h31, 1'b0, 8'h5a);
		$display("test byte done");
	endtask
	initial begin
		repeat (10) @(posedge i_mclk);
		#10;
		i_sys_rst = 1'b0;
		t_protect();
		t_erase();
		t_write();
		t_byte();
		results();
	end
endmodule

// File: logic/eepwc_ctrl.sv
`timescale 1ns/1ns
`include "eepwc_defs.svh"
// Summary of operation
// - page mode writes up to 16 bytes
// - reset clears the page buffer
// - enable falling edge clears page buffer
// - address: 9 page bits, 4 byte bits
// - page mode data writes increment low nibble
// - low nibble saturates at 0fh, extra ignored
// - data write copies byte into buffer
// - write start only in instruction after enable
// - timer ends cycle, start bit self-clears
// - write enable cleared after cycle
// - write enable cleared at power-on
// - pointer high byte resets to zero
// - cycle end sets both interrupt flags
// - vector needs all enables, stack room
// - servicing clears only multi-function flag
// - erase start only right after enable
// - sleep during operation makes it fail
// - mode bit4, read enable bit1, read bit0
// - write_enable_bit bit3, wr bit2, erase_enable_bit bit6, er bit5
// - mode clear means single byte access
// - erased page bytes read zero
module eepwc_ctrl #(
	parameter int unsigned CYC_CYCLES = `EEPWC_CYC_CNT
) (
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_sys_rst,
	// core special function register bus
	input  wire logic       i_sfr_wr,
	input  wire logic [7:0] i_sfr_addr,
	input  wire logic [7:0] i_sfr_wdata,
	input  wire logic       i_instr_end,
	output logic      [7:0] o_sfr_rdata,
	// interrupt controller side
	input  wire logic       i_global_irq_enable,
	input  wire logic       i_nv_irq_enable,
	input  wire logic       i_mf_irq_enable,
	input  wire logic       i_stack_full,
	input  wire logic       i_irq_ack,
	input  wire logic       i_nv_flag_clr,
	output logic            o_nv_irq_flag,
	output logic            o_mf_irq_flag,
	output logic            o_irq_req,
	// power mode and status
	input  wire logic       i_sleep,
	output logic            o_busy
);
	localparam int CW = 32;

	// write timer count at cycle width
	function automatic logic [CW-1:0] cyc(input int unsigned n);
		cyc = n[CW-1:0];
	endfunction

	eepwc_pkg::eepwc_state_t state;         // array operation state
	logic [CW-1:0]           cnt;           // asynchronous timer model
	logic [7:0]              ctl;           // nv_control_reg
	logic [7:0]              next_ctl;      // control after this cycle
	logic [7:0]              ptr_lo;        // pointer1_low_byte
	logic [7:0]              ptr_hi;        // pointer1_high_byte
	logic [7:0]              data_reg;      // nv_data_port
	logic [7:0]              addr_hi;       // nv_addr_high, bits 12:8 used
	logic [7:0]              addr_lo;       // nv_addr_low
	logic                    page_full;     // byte 0fh already taken
	logic                    write_enable_bit_arm;      // enable set in last instruction
	logic                    erase_enable_bit_arm;      // erase enable set last instruction
	logic [7:0]              pbuf [16];     // page buffer data
	logic [15:0]             ptag;          // page buffer byte tags
	logic [7:0]              mem [8192];    // the data array itself

	// decoded accesses
	wire ind_hit = (ptr_hi == `EEPWC_CTRL_SEC) && (ptr_lo == `EEPWC_CTRL_OFS);
	wire ctl_wr  = i_sfr_wr && (i_sfr_addr == `EEPWC_A_IND1) && ind_hit;
	wire dat_wr  = i_sfr_wr && (i_sfr_addr == `EEPWC_A_DATA);
	wire busy    = (state != eepwc_pkg::EEPWC_IDLE);
	wire page_md = ctl[`EEPWC_B_MODE];
	wire [`EEPWC_PAGE_W-1:0] page = {addr_hi[4:0], addr_lo[7:4]};
	wire [`EEPWC_BYTE_W-1:0] boff = addr_lo[3:0];
	wire [`EEPWC_ADDR_W-1:0] full_addr = {page, boff};
	wire done    = busy && (cnt == cyc(1)) && !i_sleep;
	wire abort   = busy && i_sleep;
	wire buf_wr  = dat_wr && page_md && !busy && !page_full;
	// write and erase starts are honoured only straight after their enable; a read needs only its enable
	wire wr_go   = ctl_wr && i_sfr_wdata[`EEPWC_B_WR] && ctl[`EEPWC_B_WRITE_ENABLE_BIT]
		&& write_enable_bit_arm && !busy;
	wire er_go   = ctl_wr && i_sfr_wdata[`EEPWC_B_ER] && ctl[`EEPWC_B_ERASE_ENABLE_BIT]
		&& erase_enable_bit_arm && !busy;
	wire rd_go   = ctl_wr && i_sfr_wdata[`EEPWC_B_RD] && ctl[`EEPWC_B_READ_ENABLE_BIT] && !busy;

	// next control value, start bits never set by a plain write
	always_comb begin
		next_ctl = ctl;
		if (ctl_wr) begin
			next_ctl = {1'b0, i_sfr_wdata[6], 1'b0, i_sfr_wdata[4:3], 1'b0,
				i_sfr_wdata[1], 1'b0};
			next_ctl[`EEPWC_B_WR] = wr_go;
			next_ctl[`EEPWC_B_ER] = er_go;
			next_ctl[`EEPWC_B_RD] = rd_go;
		end
		if (busy) begin
			// busy: write and erase start bits and their enables are held until the end
			next_ctl[`EEPWC_B_WR]   = ctl[`EEPWC_B_WR];
			next_ctl[`EEPWC_B_ER]   = ctl[`EEPWC_B_ER];
			next_ctl[`EEPWC_B_WRITE_ENABLE_BIT] = ctl[`EEPWC_B_WRITE_ENABLE_BIT];
			next_ctl[`EEPWC_B_ERASE_ENABLE_BIT] = ctl[`EEPWC_B_ERASE_ENABLE_BIT];
		end
		if (ctl[`EEPWC_B_RD])
			next_ctl[`EEPWC_B_RD] = 1'b0;
		if (done || abort) begin
			next_ctl[`EEPWC_B_WR]   = 1'b0;
			next_ctl[`EEPWC_B_ER]   = 1'b0;
			next_ctl[`EEPWC_B_WRITE_ENABLE_BIT] = 1'b0;
			next_ctl[`EEPWC_B_ERASE_ENABLE_BIT] = 1'b0;
		end
	end

	// a falling enable throws the buffered page away
	wire buf_clr = (ctl[`EEPWC_B_WRITE_ENABLE_BIT] && !next_ctl[`EEPWC_B_WRITE_ENABLE_BIT])
		|| (ctl[`EEPWC_B_ERASE_ENABLE_BIT] && !next_ctl[`EEPWC_B_ERASE_ENABLE_BIT]);

	// control, pointer and unlock window
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			ctl      <= `EEPWC_CTRL_RST;
			ptr_hi   <= `EEPWC_PTR_RST;
			ptr_lo   <= `EEPWC_PTR_RST;
			write_enable_bit_arm <= 1'b0;
			erase_enable_bit_arm <= 1'b0;
		end else begin
			ctl <= next_ctl;
			if (i_sfr_wr && i_sfr_addr == `EEPWC_A_PTR1_LO)
				ptr_lo <= i_sfr_wdata;
			if (i_sfr_wr && i_sfr_addr == `EEPWC_A_PTR1_HI)
				ptr_hi <= i_sfr_wdata;
			// window lasts exactly one following instruction
			if (ctl_wr && !busy) begin
				write_enable_bit_arm <= i_sfr_wdata[`EEPWC_B_WRITE_ENABLE_BIT] && !ctl[`EEPWC_B_WRITE_ENABLE_BIT];
				erase_enable_bit_arm <= i_sfr_wdata[`EEPWC_B_ERASE_ENABLE_BIT] && !ctl[`EEPWC_B_ERASE_ENABLE_BIT];
			end else if (i_instr_end) begin
				write_enable_bit_arm <= 1'b0;
				erase_enable_bit_arm <= 1'b0;
			end
		end
	end

	// timer and state; the real timer is its own oscillator, modelled here
	// a count on the system clock keeps one domain, at the price of exact timing
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			state <= eepwc_pkg::EEPWC_IDLE;
			cnt   <= '0;
		end else if (done || abort) begin
			state <= eepwc_pkg::EEPWC_IDLE;
			cnt   <= '0;
		end else if (wr_go || er_go) begin
			state <= wr_go ? eepwc_pkg::EEPWC_WRITING : eepwc_pkg::EEPWC_ERASING;
			cnt   <= cyc(CYC_CYCLES);
		end else if (busy) begin
			cnt <= cnt - cyc(1);
		end
	end

	// address, data port and in-page saturation
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			addr_hi   <= 8'h00;
			addr_lo   <= 8'h00;
			data_reg  <= 8'h00;
			page_full <= 1'b0;
		end else begin
			if (i_sfr_wr && i_sfr_addr == `EEPWC_A_ADDR_HI)
				addr_hi <= {3'b000, i_sfr_wdata[4:0]};
			if (i_sfr_wr && i_sfr_addr == `EEPWC_A_ADDR_LO) begin
				addr_lo   <= i_sfr_wdata;
				page_full <= 1'b0;
			end
			if (dat_wr && !busy)
				data_reg <= i_sfr_wdata;
			// page step: only the low nibble moves, never the page
			if (buf_wr) begin
				if (boff == `EEPWC_LAST_BYTE)
					page_full <= 1'b1;
				else
					addr_lo[3:0] <= boff + 4'h1;
			end
			if (ctl[`EEPWC_B_RD]) begin
				data_reg <= mem[full_addr];
				if (page_md && boff != `EEPWC_LAST_BYTE)
					addr_lo[3:0] <= boff + 4'h1;
			end
		end
	end

	// page buffer: cleared on reset and on a falling enable
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || buf_clr) begin
			ptag <= 16'h0000;
			for (int i = 0; i < 16; i++)
				pbuf[i] <= 8'h00;
		end else if (buf_wr) begin
			pbuf[boff] <= i_sfr_wdata;
			ptag[boff] <= 1'b1;
		end
	end

	// array commit at end of cycle; no reset, it is nonvolatile
	always_ff @(posedge i_mclk) begin
		if (done) begin
			if (page_md) begin
				for (int i = 0; i < 16; i++)
					if (ptag[i])
						mem[{page, 4'(i)}] <= (state == eepwc_pkg::EEPWC_WRITING)
							? pbuf[i] : 8'h00;
			end else begin
				mem[full_addr] <= (state == eepwc_pkg::EEPWC_WRITING)
					? data_reg : 8'h00;
			end
		end
	end

	// interrupt flags: a set in the clear cycle wins
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_nv_irq_flag <= 1'b0;
			o_mf_irq_flag <= 1'b0;
			o_irq_req     <= 1'b0;
		end else begin
			o_nv_irq_flag <= done || (o_nv_irq_flag && !i_nv_flag_clr);
			o_mf_irq_flag <= done || (o_mf_irq_flag && !i_irq_ack);
			o_irq_req <= o_mf_irq_flag && o_nv_irq_flag && i_global_irq_enable
				&& i_nv_irq_enable && i_mf_irq_enable && !i_stack_full && !i_irq_ack;
		end
	end

	// register read port and busy status, both registered
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_sfr_rdata <= 8'h00;
			o_busy      <= 1'b0;
		end else begin
			o_busy <= busy;
			unique case (i_sfr_addr)
				`EEPWC_A_PTR1_LO: o_sfr_rdata <= ptr_lo;
				`EEPWC_A_PTR1_HI: o_sfr_rdata <= ptr_hi;
				`EEPWC_A_IND1:    o_sfr_rdata <= ind_hit ? ctl : 8'h00;
				`EEPWC_A_DATA:    o_sfr_rdata <= data_reg;
				`EEPWC_A_ADDR_HI: o_sfr_rdata <= addr_hi;
				`EEPWC_A_ADDR_LO: o_sfr_rdata <= addr_lo;
				default:          o_sfr_rdata <= 8'h00;
			endcase
		end
	end

	// every check below runs on the one clock and rests during reset
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	a_write_unlock: assert property (
		$rose(state == eepwc_pkg::EEPWC_WRITING) |-> $past(write_enable_bit_arm) && $past(ctl_wr))
		else $error("write started without unlock pair");
	a_start_clear: assert property (
		done |=> !ctl[`EEPWC_B_WR] && !ctl[`EEPWC_B_ER] && !busy)
		else $error("start bit not cleared at cycle end");
	a_write_enable_bit_clear: assert property (
		(done && state == eepwc_pkg::EEPWC_WRITING) |=> !ctl[`EEPWC_B_WRITE_ENABLE_BIT])
		else $error("write enable not cleared after cycle");
	a_flags_set: assert property (
		done |=> o_nv_irq_flag && o_mf_irq_flag)
		else $error("end of cycle did not raise flags");
	a_buf_cleared: assert property (
		$fell(ctl[`EEPWC_B_WRITE_ENABLE_BIT]) |-> ptag == 16'h0000)
		else $error("page buffer kept after enable fell");
	a_nibble_sat: assert property (
		(buf_wr && boff == `EEPWC_LAST_BYTE) |=> boff == `EEPWC_LAST_BYTE && page_full)
		else $error("in-page address wrapped");
	a_nibble_step: assert property (
		(buf_wr && boff != `EEPWC_LAST_BYTE && !ctl_wr && !i_sfr_wr)
		|| (buf_wr && boff != `EEPWC_LAST_BYTE)
		|=> boff == $past(boff) + 4'h1 && page == $past(page))
		else $error("in-page address step wrong");
	a_busy_hold: assert property (
		(state == eepwc_pkg::EEPWC_WRITING) |-> ctl[`EEPWC_B_WR] && !buf_wr)
		else $error("write start dropped while busy");
	a_irq_gate: assert property (
		o_irq_req |-> $past(i_global_irq_enable && i_nv_irq_enable && i_mf_irq_enable
			&& !i_stack_full && o_nv_irq_flag && o_mf_irq_flag))
		else $error("vector request without enables");
	a_erase_unlock: assert property (
		$rose(state == eepwc_pkg::EEPWC_ERASING) |-> $past(erase_enable_bit_arm) && $past(ctl_wr))
		else $error("erase started without unlock pair");
	a_erase_buf: assert property (
		$fell(ctl[`EEPWC_B_ERASE_ENABLE_BIT]) |-> ptag == 16'h0000)
		else $error("page buffer kept after erase enable fell");
	// a cut cycle must leave the controller idle and raise no nv flag
	a_sleep_abort: assert property (
		abort |=> !busy && !ctl[`EEPWC_B_WR] && !ctl[`EEPWC_B_ER]
			&& !ctl[`EEPWC_B_WRITE_ENABLE_BIT] && !ctl[`EEPWC_B_ERASE_ENABLE_BIT] && !$rose(o_nv_irq_flag))
		else $error("sleep did not drop the cycle");
endmodule

// File: logic/eepwc_ctrl_unused_placeholder_removed.sv
`timescale 1ns/1ns

// File: logic/eepwc_defs.svh
`ifndef EEPWC_DEFS_SVH
`define EEPWC_DEFS_SVH
// special function register addresses on the core's direct bus
`define EEPWC_A_PTR1_LO 8'h01
`define EEPWC_A_PTR1_HI 8'h02
`define EEPWC_A_IND1    8'h03
`define EEPWC_A_DATA    8'h04
`define EEPWC_A_ADDR_HI 8'h05
`define EEPWC_A_ADDR_LO 8'h06
// indirect location of the control register
`define EEPWC_CTRL_OFS  8'h40
`define EEPWC_CTRL_SEC  8'h01
// control register bit positions
`define EEPWC_B_RD      0
`define EEPWC_B_READ_ENABLE_BIT    1
`define EEPWC_B_WR      2
`define EEPWC_B_WRITE_ENABLE_BIT    3
`define EEPWC_B_MODE    4
`define EEPWC_B_ER      5
`define EEPWC_B_ERASE_ENABLE_BIT    6
// reset values
`define EEPWC_CTRL_RST  8'h00
`define EEPWC_PTR_RST   8'h00
// address split: 9 page bits over 4 in-page bits
`define EEPWC_PAGE_W    9
`define EEPWC_BYTE_W    4
`define EEPWC_ADDR_W    13
`define EEPWC_LAST_BYTE 4'hf
// internal write/erase timer
`define EEPWC_CLK_MHZ   10
`define EEPWC_CYC_US    4000
`define EEPWC_CYC_CNT   (`EEPWC_CYC_US * `EEPWC_CLK_MHZ)
`endif

// File: logic/eepwc_pkg.sv
package eepwc_pkg;
	// array operation in progress
	typedef enum logic [1:0] {
		EEPWC_IDLE,
		EEPWC_WRITING,
		EEPWC_ERASING
	} eepwc_state_t;
endpackage
